// ### htd_pkg.sv
// htd_pkg: constants and carrier types for the transfer descriptor field decoder
// assumes a 32-bit avalon-mm slave and an 8-byte descriptor image
package htd_pkg;
  localparam logic [7:0] HTD_REG_CTRL = 8'h00;
  localparam logic [7:0] HTD_REG_STATUS = 8'h04;
  localparam logic [7:0] HTD_REG_FRAME = 8'h08;
  localparam logic [7:0] HTD_REG_DESC_LO = 8'h0C;
  localparam logic [7:0] HTD_REG_DESC_HI = 8'h10;
  localparam logic [7:0] HTD_REG_SCHED = 8'h14;
  localparam logic [7:0] HTD_REG_PAYLOAD = 8'h18;
  localparam logic [7:0] HTD_REG_TOKEN = 8'h1C;
  // descriptor bit positions within the 64-bit image (byte n at bits 8n+7:8n)
  localparam int HTD_POS_LEN = 32;
  localparam int HTD_POS_SPEED = 26;
  localparam int HTD_POS_DIR = 42;
  localparam int HTD_POS_PINGPONG = 46;
  localparam int HTD_POS_PAIRED = 47;
  localparam int HTD_POS_FUNC = 48;
  localparam int HTD_POS_BYTE7 = 56;
  localparam int HTD_POS_MPS = 16;
  localparam int HTD_POS_EP = 28;
  localparam int HTD_FIFO_DEPTH = 8;
  localparam int HTD_FIFO_WIDTH = 32;
  localparam logic [15:0] HTD_FRAME_RST = 16'h0000;
  localparam logic [1:0] HTD_TOK_SETUP = 2'h0;
  localparam logic [1:0] HTD_TOK_OUT = 2'h1;
  localparam logic [1:0] HTD_TOK_IN = 2'h2;
  localparam logic [1:0] HTD_TOK_RSVD = 2'h3;
  localparam logic [1:0] HTD_KIND_BULK = 2'h0;
  localparam logic [1:0] HTD_KIND_INTR = 2'h1;
  localparam logic [1:0] HTD_KIND_ISO = 2'h2;

  typedef struct packed {
    logic low_speed;
    logic [9:0] transfer_length;
    logic pong_select;
    logic paired;
    logic [1:0] token_direction;
    logic [6:0] target_function_number;
    logic [3:0] endpoint;
    logic [9:0] per_packet_byte_limit;
    logic [7:0] first_frame_select;
  } htd_fields_type;

  typedef struct packed {
    logic valid;
    logic low_speed;
    logic [1:0] pid_kind;
    logic [6:0] function_number;
    logic [3:0] endpoint;
    logic [9:0] byte_count;
    logic pong;
  } htd_token_type;
endpackage

// ### htd_fifo.sv
// htd_fifo: parameterised synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module htd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_r < (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rd_r];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### htd_top.sv
// htd_top: decodes software-written transfer descriptor fields and schedules tokens
// assumes avalon-mm master on the same clock; a link engine drains token_out
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
import htd_pkg::*;
module htd_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic frame_tick,
  output htd_token_type token_out,
  input wire logic token_done,
  output logic [31:0] payload_data,
  output logic payload_valid,
  input wire logic payload_ready
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_ISSUE = 4'b0100,
    ST_BUSY = 4'b1000
  } htd_state_type;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    return old;
  endfunction

  function automatic htd_fields_type decode(input logic [63:0] d);
    htd_fields_type f;
    f.low_speed = d[HTD_POS_SPEED];
    f.transfer_length = d[HTD_POS_LEN +: 10];
    f.pong_select = d[HTD_POS_PINGPONG];
    f.paired = d[HTD_POS_PAIRED];
    f.token_direction = d[HTD_POS_DIR +: 2];
    f.target_function_number = d[HTD_POS_FUNC +: 7];
    f.endpoint = d[HTD_POS_EP +: 4];
    f.per_packet_byte_limit = d[HTD_POS_MPS +: 10];
    f.first_frame_select = d[HTD_POS_BYTE7 +: 8];
    return f;
  endfunction

  // two descriptor slots: slot 0 holds the first buffer, slot 1 the second of a pair
  logic [63:0] desc_r [2];
  logic [1:0] active_r;
  logic [1:0] kind_r;
  logic [15:0] frame_r;
  logic [1:0] tick_sync_r;
  logic tick_prev_r;
  logic frame_start_r;
  logic cur_slot_r;
  logic first_sent_r;
  logic hold_r;
  logic [6:0] poll_cnt_r;
  logic [31:0] readdata_r;
  logic ack_r;
  htd_token_type token_r;
  htd_state_type state_r;
  htd_state_type state_nxt;

  htd_fields_type fld [2];
  for (genvar g = 0; g < 2; g++) begin : g_dec
    assign fld[g] = decode(desc_r[g]);
  end

  wire htd_fields_type cur = fld[cur_slot_r];
  wire tick_rise = tick_sync_r[1] && !tick_prev_r;
  wire req = (avs_read || avs_write) && !ack_r;
  // a write lands on the answer edge, where the master sees waitrequest low
  wire wr_en = avs_write && ack_r;
  wire [31:0] frame_merged = merge({16'h0000, frame_r}, avs_writedata, avs_byteenable);
  // software may only rewrite a slot while it is idle, so the fields never move mid-use
  wire slot_busy = (state_r != ST_IDLE);
  wire [4:0] intr_start = cur.first_frame_select[4:0];
  wire [2:0] intr_exp = cur.first_frame_select[7:5];
  wire [6:0] intr_mask = 7'((8'h01 << intr_exp) - 8'h01);
  wire intr_due = ((frame_r[6:0] & intr_mask) == (7'(intr_start) & intr_mask));
  wire iso_due = (frame_r[7:0] == cur.first_frame_select);
  wire kind_due = (kind_r == HTD_KIND_ISO) ? iso_due :
                  (kind_r == HTD_KIND_INTR) ? intr_due : 1'b1;
  // pong may start only after the ping token was finished with token_done
  wire pong_block = cur.paired && cur.pong_select && !first_sent_r;
  wire tok_ok = (cur.token_direction != HTD_TOK_RSVD);
  wire due = active_r[cur_slot_r] && kind_due && !pong_block && tok_ok;
  wire fifo_in_ready;
  wire pay_push = (state_r == ST_ISSUE) && (cur.token_direction != HTD_TOK_IN);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (active_r != 2'b00) state_nxt = ST_WAIT;
      ST_WAIT: if (due && frame_start_r || due && kind_r == HTD_KIND_BULK) state_nxt = ST_ISSUE;
      ST_ISSUE: if (fifo_in_ready || !pay_push) state_nxt = ST_BUSY;
      ST_BUSY: if (token_done) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_sync_r <= 2'b00;
      tick_prev_r <= 1'b0;
      frame_start_r <= 1'b0;
    end else begin
      tick_sync_r <= {tick_sync_r[0], frame_tick};
      tick_prev_r <= tick_sync_r[1];
      // one cycle late, so the match sees the number of the frame just begun
      frame_start_r <= tick_rise;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_r <= HTD_FRAME_RST;
    end else if (wr_en && avs_address == HTD_REG_FRAME) begin
      frame_r <= frame_merged[15:0];
    end else if (tick_rise) begin
      frame_r <= frame_r + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_en && !slot_busy && avs_address == HTD_REG_DESC_LO) begin
      desc_r[0][31:0] <= merge(desc_r[0][31:0], avs_writedata, avs_byteenable);
    end
    if (wr_en && !slot_busy && avs_address == HTD_REG_DESC_HI) begin
      desc_r[0][63:32] <= merge(desc_r[0][63:32], avs_writedata, avs_byteenable);
    end
    if (wr_en && !slot_busy && avs_address == HTD_REG_SCHED && avs_writedata[4]) begin
      desc_r[1] <= desc_r[0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_r <= 2'b00;
      kind_r <= HTD_KIND_BULK;
      cur_slot_r <= 1'b0;
      first_sent_r <= 1'b0;
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
      if (wr_en && !slot_busy && avs_address == HTD_REG_CTRL) begin
        active_r <= avs_writedata[1:0];
        kind_r <= avs_writedata[3:2];
        cur_slot_r <= 1'b0;
        first_sent_r <= 1'b0;
      end else if (state_r == ST_BUSY && token_done) begin
        active_r[cur_slot_r] <= 1'b0;
        if (cur.paired && !cur.pong_select) begin
          first_sent_r <= 1'b1;
        end
        if (active_r[~cur_slot_r] && fld[~cur_slot_r].paired) begin
          cur_slot_r <= ~cur_slot_r;
        end
      end else if (state_r == ST_IDLE && !active_r[cur_slot_r] && active_r != 2'b00) begin
        cur_slot_r <= ~cur_slot_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      token_r <= '0;
    end else if (state_r == ST_ISSUE && state_nxt == ST_BUSY) begin
      token_r.valid <= 1'b1;
      token_r.low_speed <= cur.low_speed;
      token_r.pid_kind <= cur.token_direction;
      token_r.function_number <= cur.target_function_number;
      token_r.endpoint <= cur.endpoint;
      token_r.byte_count <= cur.transfer_length;
      token_r.pong <= cur.pong_select;
    end else if (token_done) begin
      token_r.valid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      ack_r <= req;
      hold_r <= (state_r == ST_WAIT) && !due;
      case (avs_address)
        HTD_REG_CTRL: readdata_r <= {28'h0, kind_r, active_r};
        HTD_REG_STATUS: readdata_r <= {25'h0, hold_r, first_sent_r, cur_slot_r,
                                       state_r};
        HTD_REG_FRAME: readdata_r <= {16'h0, frame_r};
        HTD_REG_DESC_LO: readdata_r <= desc_r[0][31:0];
        HTD_REG_DESC_HI: readdata_r <= desc_r[0][63:32];
        HTD_REG_TOKEN: readdata_r <= {5'h00, token_r};
        default: readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = !ack_r;
  assign token_out = token_r;

  // payload path: low word of the current descriptor image stands in as sample data
  htd_fifo #(.WIDTH(HTD_FIFO_WIDTH), .DEPTH(HTD_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_data(desc_r[cur_slot_r][31:0]),
    .in_valid(pay_push),
    .in_ready(fifo_in_ready),
    .out_data(payload_data),
    .out_valid(payload_valid),
    .out_ready(payload_ready)
  );

  a_token_speed: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_ISSUE && state_nxt == ST_BUSY) |=> token_r.low_speed == $past(cur.low_speed))
    else $error("speed not carried");
  a_token_func: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(token_r.valid) |-> token_r.function_number == $past(cur.target_function_number))
    else $error("function number wrong");
  a_token_len: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(token_r.valid) |-> token_r.byte_count == $past(cur.transfer_length))
    else $error("length wrong");
  a_no_reserved: assert property (@(posedge clock) disable iff (sys_rst)
    token_r.valid |-> token_r.pid_kind != HTD_TOK_RSVD)
    else $error("reserved token issued");
  a_pong_order: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(token_r.valid) && token_r.pong && $past(cur.paired) |-> first_sent_r)
    else $error("pong before ping");
  a_iso_frame: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_WAIT && state_nxt == ST_ISSUE && kind_r == HTD_KIND_ISO)
    |-> frame_r[7:0] == cur.first_frame_select)
    else $error("iso outside start frame");
  a_intr_phase: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_WAIT && state_nxt == ST_ISSUE && kind_r == HTD_KIND_INTR)
    |-> ((frame_r[6:0] ^ 7'(intr_start)) & intr_mask) == 7'h00)
    else $error("interrupt poll off phase");
  a_desc_stable: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_BUSY && $past(state_r) == ST_BUSY) |-> $stable(desc_r[0]))
    else $error("descriptor changed in use");
  a_bus_answer: assert property (@(posedge clock) disable iff (sys_rst)
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("no bus answer");
  c_iso_issue: cover property (@(posedge clock) kind_r == HTD_KIND_ISO && $rose(token_r.valid));
  c_pair_done: cover property (@(posedge clock) $rose(token_r.valid) && token_r.pong);
  c_fifo_full: cover property (@(posedge clock) !fifo_in_ready);
  c_intr_issue: cover property (@(posedge clock) kind_r == HTD_KIND_INTR && $rose(token_r.valid));
endmodule

// ### htd_link_model.sv
// htd_link_model: far-side link engine that finishes tokens and drains payload
// assumes token_out stands until token_done and a valid/ready payload stream
`timescale 1ns/100ps
module htd_link_model
  import htd_pkg::*;
#(
  parameter int DELAY = 12
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire htd_token_type token_out,
  output logic token_done,
  input wire logic payload_valid,
  output logic payload_ready
);
  int cnt;
  // ready only every other cycle, so the fifo sees back-pressure on alternate cycles
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt <= 0;
      token_done <= 1'b0;
      payload_ready <= 1'b0;
    end else begin
      payload_ready <= ~payload_ready;
      token_done <= 1'b0;
      if (token_out.valid && !token_done) begin
        cnt <= cnt + 1;
        if (cnt == DELAY) begin
          token_done <= 1'b1;
          cnt <= 0;
        end
      end
    end
  end
endmodule

// ### tb_top.sv
// tb_top: register-level tests of the descriptor decoder against a link model
// assumes one 200 MHz clock and the one-wait-state avalon slave of htd_top
`timescale 1ns/100ps
module tb_top
  import htd_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic frame_tick = 1'b0;
  htd_token_type token_out;
  logic token_done;
  logic [31:0] payload_data;
  logic payload_valid;
  logic payload_ready;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] q;
  logic hit;
  localparam logic [31:0] LO = 32'h3040_0000;
  localparam logic [31:0] LS = 32'h0400_0000;
  htd_top dut (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_tick(frame_tick), .token_out(token_out),
    .token_done(token_done), .payload_data(payload_data), .payload_valid(payload_valid),
    .payload_ready(payload_ready));
  htd_link_model #(.DELAY(12)) link (.clock(clock), .sys_rst(sys_rst),
    .token_out(token_out), .token_done(token_done), .payload_valid(payload_valid),
    .payload_ready(payload_ready));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request rises after an edge and stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      err_count++;
      tally_and_finish();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_tok(input logic want, input int n);
    hit = 1'b0;
    repeat (n) begin
      @(posedge clock);
      if (token_out.valid === want) begin
        hit = 1'b1;
        break;
      end
    end
  endtask
  task automatic wait_idle();
    repeat (40) begin
      bus(1'b0, HTD_REG_STATUS, 32'h0);
      if (q[3:0] === 4'h1) break;
    end
    chk(q[3:0], 4'h1);
  endtask
  task automatic tick();
    @(posedge clock);
    frame_tick <= 1'b1;
    repeat (4) @(posedge clock);
    frame_tick <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  function automatic logic [31:0] hi(logic [1:0] dir, logic pp, logic pr, logic [7:0] b7);
    return {b7, 1'b0, 7'h2A, pr, pp, 2'b00, dir, 10'h008};
  endfunction
  function automatic logic [31:0] tok(logic [1:0] dir, logic pong, logic ls);
    return {5'h0, 1'b1, ls, dir, 7'h2A, 4'h3, 10'h008, pong};
  endfunction
  // periodic case: n_miss frames pass with no token, the next one issues it
  task automatic frame_case(input logic [1:0] kind, input logic [7:0] b7,
                            input logic [15:0] f0, input int n_miss);
    bus(1'b1, HTD_REG_FRAME, {16'h0, f0});
    bus(1'b1, HTD_REG_DESC_HI, hi(HTD_TOK_OUT, 1'b0, 1'b0, b7));
    bus(1'b1, HTD_REG_CTRL, {28'h0, kind, 2'b01});
    for (int k = 0; k < n_miss; k++) begin
      tick();
      wait_tok(1'b1, 20);
      chk(hit, 1'b0);
      if (kind == HTD_KIND_ISO) bus(1'b0, HTD_REG_STATUS, 32'h0);
      if (kind == HTD_KIND_ISO) chk(q[6], 1'b1);
    end
    tick();
    wait_tok(1'b1, 30);
    chk(hit, 1'b1);
    wait_idle();
    $display("frame case kind %0d byte7 %h done", kind, b7);
  endtask
  initial begin
    logic [1:0] dirs [3] = '{HTD_TOK_SETUP, HTD_TOK_OUT, HTD_TOK_IN};
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b0, HTD_REG_STATUS, 32'h0);
    chk(q[3:0], 4'h1);
    bus(1'b0, HTD_REG_FRAME, 32'h0);
    chk(q[15:0], HTD_FRAME_RST);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    // the in pass runs at low speed, the others at full speed
    foreach (dirs[i]) begin
      bus(1'b1, HTD_REG_DESC_LO, (dirs[i] == HTD_TOK_IN) ? (LO | LS) : LO);
      bus(1'b1, HTD_REG_DESC_HI, hi(dirs[i], 1'b0, 1'b0, 8'h00));
      bus(1'b1, HTD_REG_CTRL, {28'h0, HTD_KIND_BULK, 2'b01});
      wait_tok(1'b1, 30);
      chk({5'h0, token_out}, tok(dirs[i], 1'b0, dirs[i] == HTD_TOK_IN));
      bus(1'b0, HTD_REG_DESC_HI, 32'h0);
      chk(q, hi(dirs[i], 1'b0, 1'b0, 8'h00));
      wait_idle();
    end
    $display("bulk token test done");
    bus(1'b1, HTD_REG_DESC_LO, LO);
    bus(1'b1, HTD_REG_DESC_HI, hi(HTD_TOK_OUT, 1'b1, 1'b1, 8'h00));
    bus(1'b1, HTD_REG_SCHED, 32'h10);
    bus(1'b1, HTD_REG_DESC_HI, hi(HTD_TOK_OUT, 1'b0, 1'b1, 8'h00));
    bus(1'b1, HTD_REG_CTRL, {28'h0, HTD_KIND_BULK, 2'b11});
    wait_tok(1'b1, 30);
    chk({5'h0, token_out}, tok(HTD_TOK_OUT, 1'b0, 1'b0));
    bus(1'b0, HTD_REG_STATUS, 32'h0);
    chk(q[4], 1'b0);
    wait_tok(1'b0, 40);
    wait_tok(1'b1, 30);
    chk({5'h0, token_out}, tok(HTD_TOK_OUT, 1'b1, 1'b0));
    bus(1'b0, HTD_REG_STATUS, 32'h0);
    chk(q[5:4], 2'b11);
    wait_idle();
    $display("paired test done");
    frame_case(HTD_KIND_ISO, 8'h07, 16'h0005, 1);
    frame_case(HTD_KIND_INTR, 8'h41, 16'h0012, 2);
    frame_case(HTD_KIND_INTR, 8'h00, 16'h0030, 0);
    frame_case(HTD_KIND_INTR, 8'hFF, 16'h001D, 1);
    bus(1'b1, HTD_REG_DESC_HI, hi(HTD_TOK_RSVD, 1'b0, 1'b0, 8'h00));
    bus(1'b1, HTD_REG_CTRL, {28'h0, HTD_KIND_BULK, 2'b01});
    wait_tok(1'b1, 40);
    chk(hit, 1'b0);
    bus(1'b1, HTD_REG_DESC_HI, 32'h0);
    bus(1'b0, HTD_REG_DESC_HI, 32'h0);
    chk(q, hi(HTD_TOK_RSVD, 1'b0, 1'b0, 8'h00));
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b0, HTD_REG_STATUS, 32'h0);
    chk(q[3:0], 4'h1);
    $display("reserved token test done");
    tally_and_finish();
  end
endmodule
